// file: mtdc_dev.sv
// mtdc_dev.sv: step translator with automatic decay selection and chopper
`default_nettype none
// How it works
// - step high at least 1 us
// - step low at least 1 us
// - select lines pick full to sixteenth step
// - reset loads home, both bridges mixed
// - each step advances level and polarity
// - falling level selects mixed decay; full step stays slow instead
// - rising or equal level selects slow
// - resolution sampled at step rising edge
// - change resolution at common positions only
// - thermal or overcurrent returns to home
// - mixed: fast 31.25 percent, then slow
// - grounded setting pin forces mixed always
// - prefer forced mixed over automatic decay
// - direction sampled at step rising edge
// - reset pin holds home, outputs off
// - disable input turns outputs off only
// - supply-tied setting pin gives 30 us
module mtdc_dev #(
  parameter int OFF_CYCLES   = mtdc_pkg::OFF_CYC,   // fixed off-time in clocks
  parameter int BLANK_CYCLES = mtdc_pkg::BLANK_CYC  // sense blanking in clocks
) (
  input  wire logic                pclk,         // 20 MHz clock
  input  wire logic                presetn,      // async reset, active low
  mtdc_if.dev                      lnk,          // step, direction, select lines
  input  wire logic [1:0]          offtime_cfg,  // setting pin: res, gnd, vdd
  input  wire logic [15:0]         ext_off_cyc,  // off-time in clocks, resistor case
  input  wire logic [1:0]          sense_trip,   // current comparators, bridge b:a
  input  wire logic                thermal_trip, // over-temperature level
  input  wire logic                ocp_trip,     // overcurrent event pulse
  output logic [7:0]               lvl_a_q,      // winding a current level
  output logic [7:0]               lvl_b_q,      // winding b current level
  output logic [1:0]               neg_q,        // polarity b:a, 1 = negative
  output logic [1:0]               mixed_q,      // decay b:a, 1 = mixed
  output mtdc_pkg::mtdc_drv_e      drive_a_q,    // bridge a drive state
  output mtdc_pkg::mtdc_drv_e      drive_b_q,    // bridge b drive state
  output logic                     home_q        // translator at home
);
  import mtdc_pkg::*;

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (OFF_CYCLES < 1 || OFF_CYCLES > 65535)
    $error("OFF_CYCLES must lie in 1..65535");
  if (BLANK_CYCLES < 1 || BLANK_CYCLES > 65535)
    $error("BLANK_CYCLES must lie in 1..65535");

  typedef enum {CH_BLANK, CH_SENSE, CH_FAST, CH_SLOW} mtdc_chop_e;

  logic        step_prev_q;
  logic        therm_prev_q;
  logic        step_rise;
  logic        home_evt;
  logic        en_q;
  logic [5:0]  pos_q;
  logic [5:0]  size;
  logic [5:0]  pos_d;
  logic [15:0] off_cyc;
  logic [15:0] fast_cyc;
  logic [19:0] fast_prod;
  logic [7:0]  lvl_q   [2];
  logic        neg_r   [2];
  logic        mixed_r [2];
  mtdc_drv_e   drv_q   [2];

  // --------------------------------------------------------------------------
  // step edge and home events
  // --------------------------------------------------------------------------
  // inputs are synchronous, so one stage of history finds the edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_prev_q  <= 1'b0;
      therm_prev_q <= 1'b0;
    end
    else
    begin
      step_prev_q  <= lnk.step;
      therm_prev_q <= thermal_trip;
    end
  end

  assign step_rise = lnk.step & ~step_prev_q & lnk.rst_pin_n;
  assign home_evt  = ~lnk.rst_pin_n | ocp_trip | (thermal_trip & ~therm_prev_q);

  assign size  = mtdc_step_size(lnk.res_sel_bus);
  // direction only read on the edge
  assign pos_d = lnk.dir ? pos_q + size : pos_q - size;

  // --------------------------------------------------------------------------
  // translator position
  // --------------------------------------------------------------------------
  // advance one increment per step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos_q <= HOME_POS;
    else if (home_evt)
      pos_q <= HOME_POS;
    else if (step_rise)
      pos_q <= pos_d;
  end

  // home flag tracks the registered position
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      home_q <= 1'b1;
    else
      home_q <= (home_evt || (step_rise ? pos_d : pos_q) == HOME_POS);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_q <= 1'b0;
    else
      en_q <= lnk.rst_pin_n & ~lnk.out_dis & ~thermal_trip;
  end

  // --------------------------------------------------------------------------
  // off-time selection
  // --------------------------------------------------------------------------
  // fixed off-time unless a resistor sets it
  assign off_cyc   = (offtime_cfg == OSC_RES && ext_off_cyc != 16'h0000) ?
                     ext_off_cyc : 16'(OFF_CYCLES);
  assign fast_prod = 20'(off_cyc) * 20'(FAST_NUM);
  assign fast_cyc  = 16'(fast_prod >> FAST_SHR);

  // --------------------------------------------------------------------------
  // per bridge: level, polarity, decay, chopper
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_br
    logic [8:0]  wind_new;
    logic [8:0]  wind_home;
    mtdc_chop_e  chop_q;
    logic [15:0] cnt_q;

    assign wind_new  = mtdc_wind(pos_d, 1'(i));
    assign wind_home = mtdc_wind(HOME_POS, 1'(i));

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        lvl_q[i] <= LVL_TAB[8];
        neg_r[i] <= 1'b0;
      end
      else if (home_evt)
      begin
        lvl_q[i] <= wind_home[7:0];
        neg_r[i] <= wind_home[8];
      end
      else if (step_rise)
      begin
        lvl_q[i] <= wind_new[7:0];
        neg_r[i] <= wind_new[8];
      end
    end

    // decay picked from the level trend at each step
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        mixed_r[i] <= 1'b1;
      else if (home_evt)
        mixed_r[i] <= 1'b1;
      else if (step_rise)
      begin
        if (offtime_cfg == OSC_GND)
          mixed_r[i] <= 1'b1;
        // full step stays slow in automatic mode
        else if (size == FULL_SIZE)
          mixed_r[i] <= 1'b0;
        else
          mixed_r[i] <= (wind_new[7:0] < lvl_q[i]);
      end
    end

    // chopper; off-time counted from the trip, fast part first when mixed
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        chop_q <= CH_BLANK;
        cnt_q  <= 16'h0000;
      end
      else if (!en_q)
      begin
        chop_q <= CH_BLANK;
        cnt_q  <= 16'h0000;
      end
      else
      begin
        case (chop_q)
          CH_BLANK:
            if (cnt_q == 16'(BLANK_CYCLES - 1))
            begin
              chop_q <= CH_SENSE;
              cnt_q  <= 16'h0000;
            end
            else
              cnt_q <= cnt_q + 16'h0001;
          CH_SENSE:
            if (sense_trip[i])
            begin
              chop_q <= (mixed_r[i] && fast_cyc != 16'h0000) ? CH_FAST : CH_SLOW;
              cnt_q  <= 16'h0000;
            end
          CH_FAST:
          begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == fast_cyc - 16'h0001)
              chop_q <= CH_SLOW;
          end
          CH_SLOW:
            if (cnt_q >= off_cyc - 16'h0001)
            begin
              chop_q <= CH_BLANK;
              cnt_q  <= 16'h0000;
            end
            else
              cnt_q <= cnt_q + 16'h0001;
          default:
          begin
            chop_q <= CH_BLANK;
            cnt_q  <= 16'h0000;
          end
        endcase
      end
    end

    // drive off under reset or disable
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        drv_q[i] <= DRV_OFF;
      else if (!en_q)
        drv_q[i] <= DRV_OFF;
      else
      begin
        case (chop_q)
          CH_FAST:  drv_q[i] <= DRV_FAST;
          CH_SLOW:  drv_q[i] <= DRV_SLOW;
          default:  drv_q[i] <= DRV_ON;
        endcase
      end
    end
  end

  // outputs taken straight from the bridge flops
  assign lvl_a_q   = lvl_q[0];
  assign lvl_b_q   = lvl_q[1];
  assign neg_q     = {neg_r[1], neg_r[0]};
  assign mixed_q   = {mixed_r[1], mixed_r[0]};
  assign drive_a_q = drv_q[0];
  assign drive_b_q = drv_q[1];
endmodule : mtdc_dev
`default_nettype wire

// file: mtdc_pkg.sv
// mtdc_pkg.sv: shared constants, types and helpers of the step translator pair
`default_nettype none
package mtdc_pkg;
  // --------------------------------------------------------------------------
  // clock and link timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 50;
  localparam int PULSE_HIGH_MIN_NS = 1000;
  localparam int PULSE_LOW_MIN_NS  = 1000;
  localparam int SETUP_MIN_NS      = 200;
  localparam int OFF_TIME_NS       = 30000;
  localparam int BLANK_NS          = 1000;
  // least times round up
  localparam int HIGH_CYC  = (PULSE_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_CYC   = (PULSE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CYC   = OFF_TIME_NS / CLK_PERIOD_NS;
  localparam int BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
  // fast share of the off-time: 5/16 = 31.25 %
  localparam int FAST_NUM  = 5;
  localparam int FAST_SHR  = 4;

  // --------------------------------------------------------------------------
  // translator
  // --------------------------------------------------------------------------
  localparam logic [5:0] HOME_POS  = 6'h08;
  localparam logic [5:0] FULL_SIZE = 6'h10;
  localparam logic [7:0] LVL_TAB [17] = '{8'h00, 8'h0a, 8'h14, 8'h1d, 8'h26, 8'h2f, 8'h38,
    8'h3f, 8'h47, 8'h4d, 8'h53, 8'h58, 8'h5c, 8'h60, 8'h62, 8'h64, 8'h64};
  // off-time setting pin codes
  localparam logic [1:0] OSC_RES = 2'h0;
  localparam logic [1:0] OSC_GND = 2'h1;
  localparam logic [1:0] OSC_VDD = 2'h2;

  typedef enum logic [1:0] {DRV_OFF, DRV_ON, DRV_FAST, DRV_SLOW} mtdc_drv_e;

  // --------------------------------------------------------------------------
  // controller registers
  // --------------------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STEP   = 8'h04;
  localparam logic [7:0]  REG_COUNT  = 8'h08;
  localparam int          CTRL_DIR   = 0;
  localparam int          CTRL_RES   = 1;
  localparam int          CTRL_DIS   = 4;
  localparam int          CTRL_RUN   = 5;
  localparam logic [5:0]  CTRL_RST   = 6'h20;

  // microsteps (in sixteenths) per step; bit0..2 = res_sel_a..c
  function automatic logic [5:0] mtdc_step_size(input logic [2:0] sel);
    case (sel)
      3'h1, 3'h5: return 6'h08;
      3'h2, 3'h6: return 6'h04;
      3'h3:       return 6'h02;
      3'h7:       return 6'h01;
      default:    return FULL_SIZE;
    endcase
  endfunction : mtdc_step_size

  // {negative, level} of one winding at a position; a follows cosine, b sine
  function automatic logic [8:0] mtdc_wind(input logic [5:0] pos, input logic is_b);
    logic [4:0] k;
    k = {1'b0, pos[3:0]};
    if (pos[4] ^ ~is_b)
      k = 5'h10 - k;
    return {(is_b ? pos[5] : (pos[5] ^ pos[4])), LVL_TAB[k]};
  endfunction : mtdc_wind
endpackage : mtdc_pkg
`default_nettype wire

// file: mtdc_if.sv
// mtdc_if.sv: logic link between step controller and translator
`default_nettype none
interface mtdc_if;
  logic       step;        // step pulse, advances on rising edge
  logic       dir;         // direction level
  logic [2:0] res_sel_bus; // res_sel_a/b/c in bits 0/1/2
  logic       out_dis;     // high disables bridge outputs
  logic       rst_pin_n;   // translator reset, active low

  modport dev (input step, dir, res_sel_bus, out_dis, rst_pin_n);
  modport ctl (output step, dir, res_sel_bus, out_dis, rst_pin_n);
endinterface : mtdc_if
`default_nettype wire

// file: mtdc_ctrl.sv
// mtdc_ctrl.sv: APB-programmed step pulse generator driving the translator link
`default_nettype none
module mtdc_ctrl (
  input  wire logic        pclk,      // 20 MHz clock
  input  wire logic        presetn,   // async reset, active low
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB access phase
  input  wire logic        pwrite,    // APB write
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic [31:0]      prdata_q,  // APB read data
  output logic             pready_q,  // APB ready
  output logic             pslverr_q, // APB error, unmapped address
  mtdc_if.ctl              lnk        // link to the translator
);
  import mtdc_pkg::*;

  typedef enum {SG_IDLE, SG_LOW, SG_HIGH} mtdc_sg_e;

  // low wait covers both the low time and the select setup time
  localparam int LOW_WAIT = (LOW_CYC > SETUP_CYC) ? LOW_CYC : SETUP_CYC;

  logic [5:0]  ctrl_q;
  logic [15:0] pend_q;
  logic [31:0] count_q;
  logic        step_q;
  logic        dir_q;
  logic [2:0]  res_q;
  logic        dis_q;
  logic        run_q;
  mtdc_sg_e    sg_q;
  logic [4:0]  cnt_q;
  logic        setup;
  logic        wr;
  logic        mapped;
  logic        issue;

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite & pready_q;
  assign mapped = paddr == REG_CTRL || paddr == REG_STEP || paddr == REG_COUNT;

  // answer in the first access cycle; read data captured at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite)
      begin
        case (paddr)
          REG_CTRL:  prdata_q <= {26'h0, ctrl_q};
          REG_STEP:  prdata_q <= {16'h0, pend_q};
          REG_COUNT: prdata_q <= count_q;
          default:   prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control shadow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= CTRL_RST;
    else if (wr && paddr == REG_CTRL)
      ctrl_q <= pwdata[5:0];
  end

  // pending steps: a write adds, an issued step removes, both may coincide
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_q <= 16'h0000;
    else
      pend_q <= pend_q + ((wr && paddr == REG_STEP) ? pwdata[15:0] : 16'h0000)
                - {15'h0, issue};
  end

  // issued step total; an issue in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= 32'h0000_0000;
    else if (wr && paddr == REG_COUNT)
      count_q <= {31'h0, issue};
    else if (issue)
      count_q <= count_q + 32'h0000_0001;
  end

  // --------------------------------------------------------------------------
  // step pulse generator
  // --------------------------------------------------------------------------
  assign issue = (sg_q == SG_LOW) && (cnt_q == 5'(LOW_WAIT - 1));

  // settings move only while idle, so they never change near a rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_q <= 1'b0;
      res_q <= 3'h0;
      dis_q <= 1'b0;
      run_q <= 1'b0;
    end
    else if (sg_q == SG_IDLE)
    begin
      dir_q <= ctrl_q[CTRL_DIR];
      res_q <= ctrl_q[CTRL_RES +: 3];
      dis_q <= ctrl_q[CTRL_DIS];
      run_q <= ctrl_q[CTRL_RUN];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sg_q   <= SG_IDLE;
      cnt_q  <= 5'h00;
      step_q <= 1'b0;
    end
    else
    begin
      case (sg_q)
        SG_IDLE:
          if (pend_q != 16'h0000 && run_q && ctrl_q[CTRL_RUN])
          begin
            sg_q  <= SG_LOW;
            cnt_q <= 5'h00;
          end
        SG_LOW:
          if (issue)
          begin
            sg_q   <= SG_HIGH;
            cnt_q  <= 5'h00;
            step_q <= 1'b1;
          end
          else
            cnt_q <= cnt_q + 5'h01;
        SG_HIGH:
          if (cnt_q == 5'(HIGH_CYC - 1))
          begin
            sg_q   <= SG_IDLE;
            cnt_q  <= 5'h00;
            step_q <= 1'b0;
          end
          else
            cnt_q <= cnt_q + 5'h01;
        default:
        begin
          sg_q   <= SG_IDLE;
          cnt_q  <= 5'h00;
          step_q <= 1'b0;
        end
      endcase
    end
  end

  // link pins straight from flops
  assign lnk.step        = step_q;
  assign lnk.dir         = dir_q;
  assign lnk.res_sel_bus = res_q;
  assign lnk.out_dis     = dis_q;
  assign lnk.rst_pin_n   = run_q;
endmodule : mtdc_ctrl
`default_nettype wire

// file: mtdc_assertions.sv
// mtdc_assertions.sv: checks on the translator link and its outputs
`default_nettype none
module mtdc_assertions #(
  parameter int OFF_CYCLES = mtdc_pkg::OFF_CYC   // off-time in clocks
) (
  input wire logic                pclk,          // 20 MHz clock
  input wire logic                presetn,       // async reset, active low
  input wire logic                step,          // step pulse
  input wire logic [2:0]          res_sel_bus,   // select lines
  input wire logic                out_dis,       // output disable
  input wire logic                rst_pin_n,     // translator reset
  input wire logic [1:0]          offtime_cfg,   // setting pin code
  input wire logic [15:0]         ext_off_cyc,   // resistor off-time
  input wire logic                thermal_trip,  // over-temperature
  input wire logic                ocp_trip,      // overcurrent pulse
  input wire logic [7:0]          lvl_a_q,       // level a
  input wire logic [7:0]          lvl_b_q,       // level b
  input wire logic [1:0]          neg_q,         // polarity b:a
  input wire logic [1:0]          mixed_q,       // decay b:a
  input wire mtdc_pkg::mtdc_drv_e drive_a_q,     // bridge a state
  input wire logic                home_q         // at home
);
  import mtdc_pkg::*;
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic [5:0] hi_cnt_q;
  logic [5:0] lo_cnt_q;
  logic [7:0] fast_cnt_q;
  int         fast_len;

  // pulse widths; saturate so long idle cannot wrap to a short count
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi_cnt_q <= 6'h00;
    else
      hi_cnt_q <= step ? hi_cnt_q + {5'h00, ~&hi_cnt_q} : 6'h00;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      lo_cnt_q <= 6'h00;
    else
      lo_cnt_q <= !step ? lo_cnt_q + {5'h00, ~&lo_cnt_q} : 6'h00;

  // length of the fast part of the current off-time
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      fast_cnt_q <= 8'h00;
    else
      fast_cnt_q <= (drive_a_q == DRV_FAST) ? fast_cnt_q + 8'h01 : 8'h00;

  // fast share is 5/16 of whichever off-time is in force
  assign fast_len = ((offtime_cfg == OSC_RES && ext_off_cyc != 16'h0000) ?
                     int'(ext_off_cyc) : OFF_CYCLES) * 5 / 16;

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_step;
    $rose(step) && rst_pin_n;
  endsequence
  sequence s_auto;
    s_step ##0 (offtime_cfg != OSC_GND && res_sel_bus[1:0] != 2'h0);
  endsequence

  a_high_width: assert property ($fell(step) |-> hi_cnt_q >= 6'h14)
    else $error("step high too short");
  a_low_width: assert property ($rose(step) |-> lo_cnt_q >= 6'h14)
    else $error("step low too short");
  a_reset_home: assert property (!rst_pin_n |=> home_q && lvl_a_q == 8'h47
    && lvl_b_q == 8'h47 && neg_q == 2'h0) else $error("reset pin did not hold home");
  a_reset_off: assert property (!rst_pin_n [*3] |-> drive_a_q == DRV_OFF)
    else $error("bridge driven in reset");
  a_dis_off: assert property (out_dis [*3] |-> drive_a_q == DRV_OFF)
    else $error("bridge driven while disabled");
  a_still_idle: assert property (rst_pin_n && !$rose(step) && !ocp_trip && !thermal_trip
    && !$past(ocp_trip) && !$past(thermal_trip) |=> $stable(lvl_a_q) && $stable(lvl_b_q)
    && $stable(neg_q)) else $error("outputs moved without a step");
  a_decay_a: assert property (s_auto |=> mixed_q[0] == (lvl_a_q < $past(lvl_a_q)))
    else $error("wrong decay on bridge a");
  a_decay_b: assert property (s_auto |=> mixed_q[1] == (lvl_b_q < $past(lvl_b_q)))
    else $error("wrong decay on bridge b");
  a_gnd_mixed: assert property (s_step ##0 offtime_cfg == OSC_GND |=> mixed_q == 2'h3)
    else $error("grounded setting not mixed");
  a_fast_share: assert property (drive_a_q == DRV_SLOW && $past(drive_a_q) == DRV_FAST
    |-> int'(fast_cnt_q) == fast_len) else $error("fast part of off-time wrong");
endmodule : mtdc_assertions
`default_nettype wire

// file: tb.sv
// tb.sv: self-checking bench joining controller and translator
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mtdc_pkg::*;
  localparam int OFF = 32;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        thermal_trip = 1'b0, ocp_trip = 1'b0, pready_q, pslverr_q, home_q;
  logic [7:0]  paddr = 8'h00, lvl_a_q, lvl_b_q;
  logic [31:0] pwdata = 32'h0, prdata_q;
  logic [1:0]  offtime_cfg = OSC_VDD, sense_trip = 2'h0, neg_q, mixed_q;
  logic [15:0] ext_off_cyc = 16'h0000;
  mtdc_drv_e   drive_a_q, drive_b_q;
  int          n_errors = 0, tests_run = 0, pos = 8, f, s;
  logic [7:0]  lt [17] = '{8'h00, 8'h0a, 8'h14, 8'h1d, 8'h26, 8'h2f, 8'h38, 8'h3f, 8'h47,
                           8'h4d, 8'h53, 8'h58, 8'h5c, 8'h60, 8'h62, 8'h64, 8'h64};
  logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};

  mtdc_if lnk ();
  mtdc_ctrl i_mtdc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .lnk(lnk));
  mtdc_dev #(.OFF_CYCLES(OFF), .BLANK_CYCLES(4)) i_mtdc_dev (.pclk(pclk), .presetn(presetn),
    .lnk(lnk), .offtime_cfg(offtime_cfg), .ext_off_cyc(ext_off_cyc), .sense_trip(sense_trip),
    .thermal_trip(thermal_trip), .ocp_trip(ocp_trip), .lvl_a_q(lvl_a_q), .lvl_b_q(lvl_b_q),
    .neg_q(neg_q), .mixed_q(mixed_q), .drive_a_q(drive_a_q), .drive_b_q(drive_b_q),
    .home_q(home_q));
  mtdc_assertions #(.OFF_CYCLES(OFF)) i_mtdc_assertions (.pclk(pclk), .presetn(presetn),
    .step(lnk.step), .res_sel_bus(lnk.res_sel_bus), .out_dis(lnk.out_dis),
    .rst_pin_n(lnk.rst_pin_n), .offtime_cfg(offtime_cfg), .ext_off_cyc(ext_off_cyc),
    .thermal_trip(thermal_trip), .ocp_trip(ocp_trip), .lvl_a_q(lvl_a_q), .lvl_b_q(lvl_b_q),
    .neg_q(neg_q), .mixed_q(mixed_q), .drive_a_q(drive_a_q), .home_q(home_q));

  // 20 MHz clock
  always #25 pclk = ~pclk;

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; waits on pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_q !== 1'b1)
      @(posedge pclk);
    q = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [32:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, exp[31:0], q);
    chk("pslverr", {31'h0, exp[32]}, {31'h0, e});
  endtask : rdc

  // {negative, level} of a winding; a is cosine, b is sine
  function automatic logic [8:0] wind(input int p, input logic b);
    int q;
    int r;
    q = (p >> 4) & 3;
    r = p & 15;
    return {(b ? q >= 2 : (q == 1 || q == 2)), lt[((q & 1) != b) ? r : 16 - r]};
  endfunction : wind

  task automatic cmp_pos();
    chk("level a", {23'h0, wind(pos, 1'b0)}, {23'h0, neg_q[0], lvl_a_q});
    chk("level b", {23'h0, wind(pos, 1'b1)}, {23'h0, neg_q[1], lvl_b_q});
  endtask : cmp_pos

  // one step with settings; up = {run, disable}
  task automatic step1(input logic [2:0] sel, input logic d, input logic [1:0] up);
    logic [8:0]  ea, eb, na, nb;
    logic [31:0] q;
    logic        e;
    int          sz;
    sz = (sel == 3'h7) ? 1 : (sel == 3'h3) ? 2 : sel[1] ? 4 : sel[0] ? 8 : 16;
    ea = wind(pos, 1'b0);
    eb = wind(pos, 1'b1);
    wr(REG_CTRL, {26'h0, up, sel, d});
    repeat (25) @(posedge pclk);
    if (up[1])
      cmp_pos();
    // run bit low: controller never issues
    if (up[1])
    begin
      wr(REG_STEP, 32'h1);
      do apb(1'b0, REG_STEP, 32'h0, q, e);
      while (q[15:0] !== 16'h0000);
    end
    repeat (25) @(posedge pclk);
    pos = up[1] ? (pos + (d ? sz : -sz)) & 63 : 8;
    na = wind(pos, 1'b0);
    nb = wind(pos, 1'b1);
    cmp_pos();
    chk("decay", (offtime_cfg == OSC_GND || !up[1]) ? 3 : (sz == 16) ? 0 :
        {nb[7:0] < eb[7:0], na[7:0] < ea[7:0]}, {30'h0, mixed_q});
    if (up != 2'b10)
      chk("drive off", {DRV_OFF, DRV_OFF}, {drive_b_q, drive_a_q});
  endtask : step1

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // watchdog, far beyond the fewer than 2000 clocks the tests need
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    cmp_pos();
    chk("reset state", {8'h3, DRV_OFF, DRV_OFF, 1'b1}, {mixed_q, drive_b_q, drive_a_q, home_q});
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ctrl", REG_CTRL, 33'h20);
    rdc("unmapped", 8'h0c, 33'h100000000);
    $display("test reset done");
    for (int k = 0; k < 2; k++)
    begin
      offtime_cfg <= k ? OSC_RES : OSC_VDD;
      ext_off_cyc <= 16'h0028;
      while (drive_a_q !== DRV_ON)
        @(posedge pclk);
      sense_trip <= 2'h1;
      while (drive_a_q !== DRV_FAST)
        @(posedge pclk);
      sense_trip <= 2'h0;
      for (f = 0; drive_a_q === DRV_FAST; f++)
        @(posedge pclk);
      for (s = 0; drive_a_q === DRV_SLOW; s++)
        @(posedge pclk);
      chk("fast part", (k ? 40 : OFF) * 5 / 16, f);
      chk("off-time", k ? 40 : OFF, f + s);
    end
    offtime_cfg <= OSC_VDD;
    $display("test chopper done");
    foreach (codes[i])
      step1(codes[i], 1'b1, 2'b10);
    foreach (codes[i])
      step1(codes[4 - i], 1'b0, 2'b10);
    rdc("count", REG_COUNT, 33'ha);
    $display("test resolutions done");
    offtime_cfg <= OSC_GND;
    step1(3'h7, 1'b1, 2'b10);
    step1(3'h7, 1'b1, 2'b10);
    offtime_cfg <= OSC_VDD;
    step1(3'h2, 1'b1, 2'b11);
    step1(3'h1, 1'b1, 2'b00);
    $display("test gnd, disable, reset pin done");
    for (int k = 0; k < 2; k++)
    begin
      step1(3'h2, 1'b1, 2'b10);
      thermal_trip <= (k == 0);
      ocp_trip <= (k == 1);
      @(posedge pclk);
      ocp_trip <= 1'b0;
      repeat (4) @(posedge pclk);
      thermal_trip <= 1'b0;
      pos = 8;
      repeat (4) @(posedge pclk);
      cmp_pos();
      chk("home", 1, {31'h0, home_q});
    end
    $display("test protection done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
